// file: src/panel_setup_cfg.svh
// constants for the panel driver setup command block
// assumes a 10 MHz core clock; included by bare name
`ifndef PANEL_SETUP_CFG_SVH
`define PANEL_SETUP_CFG_SVH

// command codes, which double as register offsets
`define REG_GATE_OUTPUT_SETUP        8'h01
`define REG_GATE_HIGH_LEVEL          8'h03
`define REG_SOURCE_LEVELS            8'h04
`define CMD_INIT_CODE_PROGRAM        8'h08
`define REG_INITIAL_CODE_SETTING     8'h09
`define CMD_INIT_CODE_LOAD           8'h0a
`define REG_BOOSTER_SOFTSTART        8'h0c
`define REG_SLEEP_CONTROL            8'h10
`define REG_ADDRESS_STEP_SETUP       8'h11
`define CMD_SOFT_RESET               8'h12
`define REG_HIGH_VOLTAGE_READY_CHECK 8'h14
`define REG_SUPPLY_LEVEL_CHECK       8'h15
`define REG_THERMAL_SOURCE_SELECT    8'h18

// reset values
`define RST_GATE_COUNT     9'h127
`define RST_GATE_HIGH      5'h00
`define RST_SRC_POS_A      8'h41
`define RST_SRC_POS_B      8'ha8
`define RST_SRC_NEG        8'h32
`define RST_BOOST_PH1      7'h0b
`define RST_BOOST_PH2      7'h1c
`define RST_BOOST_PH3      7'h16
`define RST_BOOST_DUR      6'h0f
`define RST_SLEEP          2'h0
`define RST_ADDR_STEP      3'h3
`define RST_HV_CHECK       7'h00
`define RST_SUPPLY_LEVEL   3'h4
`define RST_THERMAL        8'h48

// field positions
`define BIT_FIRST_GATE     2
`define BIT_INTERLACE      1
`define BIT_UPDATE_AXIS    2

// timing
`define CLK_KHZ            10000
`define COOL_UNIT_MS       10
`define SOFT_RESET_CYCLES  16'h0010
`define SUPPLY_CHECK_CYCLES 16'h0020

`endif

// file: src/panel_setup_pkg.sv
// types for the panel driver setup command block
// no dependencies
package panel_setup_pkg;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_SRST  = 6'b000010,
    ST_PROG  = 6'b000100,
    ST_COOL  = 6'b001000,
    ST_CHECK = 6'b010000,
    ST_VCI   = 6'b100000
  } seq_state_e;

  typedef logic [7:0] byte_t;

endpackage

// file: src/panel_driver_setup_commands.sv
// setup command decoder and parameter registers of the panel driver
// assumes a 4-wire write-only serial host port sampled by mclk,
// analog status inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
`include "panel_setup_cfg.svh"

module panel_driver_setup_commands #(
  parameter int COOL_CYCLES = `COOL_UNIT_MS * `CLK_KHZ
) (
  // clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       ce,
  // serial host port
  input  wire logic       csn,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       dc_select,
  output logic            busy,
  // stage enables and analog status
  input  wire logic       clock_stage_on,
  input  wire logic       analog_stage_on,
  input  wire logic       high_drive_voltage_ok,
  input  wire logic       supply_input_level_low,
  input  wire logic       otp_done,
  // operation strobes
  output logic            otp_program_start,
  output logic            init_code_load_start,
  // status results
  output logic            hv_ready_result,
  output logic            supply_low_result,
  // gate setup
  output logic [8:0]      gate_line_count,
  output logic            first_gate_select,
  output logic            interlace_scan_select,
  output logic [4:0]      gate_high_level,
  // source levels
  output logic [7:0]      positive_source_level_a,
  output logic [7:0]      positive_source_level_b,
  output logic [7:0]      negative_source_level,
  // initial code and booster
  output logic [31:0]     initial_code,
  output logic [7:0]      booster_phase1,
  output logic [7:0]      booster_phase2,
  output logic [7:0]      booster_phase3,
  output logic [7:0]      booster_duration,
  // sleep, address stepping, sensing
  output logic [1:0]      sleep_mode,
  output logic [1:0]      address_step_direction,
  output logic            address_update_axis,
  output logic [6:0]      hv_check_setting,
  output logic [2:0]      supply_level_code,
  output logic [7:0]      thermal_source
);

  // pin synchronisers: stage 1 feeds only stage 2
  // idle levels at reset (csn high, scl low) keep a false edge away
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic       scl_prev_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_q    <= 6'h01;
      sync2_q    <= 6'h01;
      scl_prev_q <= 1'b0;
    end else if (ce) begin
      sync1_q    <= {supply_input_level_low, high_drive_voltage_ok, dc_select, sda, scl, csn};
      sync2_q    <= sync1_q;
      scl_prev_q <= sync2_q[1];
    end
  end

  logic csn_s;
  logic scl_s;
  logic sda_s;
  logic dc_s;
  logic hv_ok_s;
  logic vci_low_s;
  assign csn_s     = sync2_q[0];
  assign scl_s     = sync2_q[1];
  assign sda_s     = sync2_q[2];
  assign dc_s      = sync2_q[3];
  assign hv_ok_s   = sync2_q[4];
  assign vci_low_s = sync2_q[5];

  // byte assembly, msb first on rising serial clock
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic       byte_stb;
  logic [7:0] byte_val;
  logic       scl_rise;

  assign scl_rise = scl_s & ~scl_prev_q & ~csn_s;
  assign byte_val = {shift_q, sda_s};
  assign byte_stb = ce & scl_rise & (bit_cnt_q == 3'h7);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
    end else if (ce) begin
      if (csn_s) begin
        bit_cnt_q <= 3'h0;
      end else if (scl_rise) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        shift_q   <= byte_val[6:0];
      end
    end
  end

  // accepted bytes; sleep blocks everything until hardware reset
  panel_setup_pkg::seq_state_e state_q;
  logic accept;
  logic cmd_stb;
  logic par_stb;

  assign accept  = byte_stb & (state_q == panel_setup_pkg::ST_IDLE) & (sleep_mode == 2'h0);
  assign cmd_stb = accept & ~dc_s;
  assign par_stb = accept & dc_s;

  // current command and parameter index
  panel_setup_pkg::byte_t cmd_q;
  logic [2:0] idx_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_q <= 8'h00;
      idx_q <= 3'h0;
    end else if (ce) begin
      if (cmd_stb) begin
        cmd_q <= byte_val;
        idx_q <= 3'h0;
      end else if (par_stb && idx_q != 3'h7) begin
        idx_q <= idx_q + 3'h1;
      end
    end
  end

  logic soft_reset_go;
  assign soft_reset_go = cmd_stb & (byte_val == `CMD_SOFT_RESET);

  // first parameter byte of a command; decoded for sleep control and both check starts
  function automatic logic first_par(input logic stb, input panel_setup_pkg::byte_t cur,
                                     input logic [2:0] idx, input panel_setup_pkg::byte_t code);
    first_par = stb & (cur == code) & (idx == 3'h0);
  endfunction

  // power-on address step byte, split into its two fields
  localparam logic [2:0] ADDR_STEP_RST = `RST_ADDR_STEP;

  // sleep setting survives soft reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sleep_mode <= `RST_SLEEP;
    end else if (ce && first_par(par_stb, cmd_q, idx_q, `REG_SLEEP_CONTROL)) begin
      sleep_mode <= byte_val[1:0];
    end
  end

  // parameter registers; undefined codes are stored as written
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gate_line_count         <= `RST_GATE_COUNT;
      first_gate_select       <= 1'b0;
      interlace_scan_select   <= 1'b0;
      gate_high_level         <= `RST_GATE_HIGH;
      positive_source_level_a <= `RST_SRC_POS_A;
      positive_source_level_b <= `RST_SRC_POS_B;
      negative_source_level   <= `RST_SRC_NEG;
      initial_code            <= 32'h0000_0000;
      booster_phase1          <= {1'b1, `RST_BOOST_PH1};
      booster_phase2          <= {1'b1, `RST_BOOST_PH2};
      booster_phase3          <= {1'b1, `RST_BOOST_PH3};
      booster_duration        <= {2'h0, `RST_BOOST_DUR};
      address_step_direction  <= ADDR_STEP_RST[1:0];
      address_update_axis     <= ADDR_STEP_RST[`BIT_UPDATE_AXIS];
      hv_check_setting        <= `RST_HV_CHECK;
      supply_level_code       <= `RST_SUPPLY_LEVEL;
      thermal_source          <= `RST_THERMAL;
    end else if (ce) begin
      if (soft_reset_go) begin
        gate_line_count         <= `RST_GATE_COUNT;
        first_gate_select       <= 1'b0;
        interlace_scan_select   <= 1'b0;
        gate_high_level         <= `RST_GATE_HIGH;
        positive_source_level_a <= `RST_SRC_POS_A;
        positive_source_level_b <= `RST_SRC_POS_B;
        negative_source_level   <= `RST_SRC_NEG;
        initial_code            <= 32'h0000_0000;
        booster_phase1          <= {1'b1, `RST_BOOST_PH1};
        booster_phase2          <= {1'b1, `RST_BOOST_PH2};
        booster_phase3          <= {1'b1, `RST_BOOST_PH3};
        booster_duration        <= {2'h0, `RST_BOOST_DUR};
        address_step_direction  <= ADDR_STEP_RST[1:0];
        address_update_axis     <= ADDR_STEP_RST[`BIT_UPDATE_AXIS];
        hv_check_setting        <= `RST_HV_CHECK;
        supply_level_code       <= `RST_SUPPLY_LEVEL;
        thermal_source          <= `RST_THERMAL;
      end else if (par_stb) begin
        case (cmd_q)
          `REG_GATE_OUTPUT_SETUP: begin
            if (idx_q == 3'h0) gate_line_count[7:0] <= byte_val;
            if (idx_q == 3'h1) gate_line_count[8] <= byte_val[0];
            if (idx_q == 3'h2) begin
              first_gate_select     <= byte_val[`BIT_FIRST_GATE];
              interlace_scan_select <= byte_val[`BIT_INTERLACE];
            end
          end
          `REG_GATE_HIGH_LEVEL: begin
            if (idx_q == 3'h0) gate_high_level <= byte_val[4:0];
          end
          `REG_SOURCE_LEVELS: begin
            // ordering of a over b is the host's duty, not checked here
            if (idx_q == 3'h0) positive_source_level_a <= byte_val;
            if (idx_q == 3'h1) positive_source_level_b <= byte_val;
            if (idx_q == 3'h2) negative_source_level <= byte_val;
          end
          `REG_INITIAL_CODE_SETTING: begin
            if (idx_q < 3'h4) initial_code[8*(3-idx_q) +: 8] <= byte_val;
          end
          `REG_BOOSTER_SOFTSTART: begin
            // bit 7 of each phase byte is fixed high whatever is sent
            if (idx_q == 3'h0) booster_phase1 <= {1'b1, byte_val[6:0]};
            if (idx_q == 3'h1) booster_phase2 <= {1'b1, byte_val[6:0]};
            if (idx_q == 3'h2) booster_phase3 <= {1'b1, byte_val[6:0]};
            if (idx_q == 3'h3) booster_duration <= {2'h0, byte_val[5:0]};
          end
          `REG_ADDRESS_STEP_SETUP: begin
            if (idx_q == 3'h0) begin
              address_step_direction <= byte_val[1:0];
              address_update_axis    <= byte_val[`BIT_UPDATE_AXIS];
            end
          end
          `REG_HIGH_VOLTAGE_READY_CHECK: begin
            if (idx_q == 3'h0) hv_check_setting <= byte_val[6:0];
          end
          `REG_SUPPLY_LEVEL_CHECK: begin
            if (idx_q == 3'h0) supply_level_code <= byte_val[2:0];
          end
          `REG_THERMAL_SOURCE_SELECT: begin
            if (idx_q == 3'h0) thermal_source <= byte_val;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // operation sequencer
  logic stages_on;
  logic hv_go;
  logic vci_go;
  assign stages_on = clock_stage_on & analog_stage_on;
  assign hv_go  = first_par(par_stb, cmd_q, idx_q, `REG_HIGH_VOLTAGE_READY_CHECK) & stages_on;
  assign vci_go = first_par(par_stb, cmd_q, idx_q, `REG_SUPPLY_LEVEL_CHECK) & stages_on;

  logic [19:0] timer_q;
  logic [2:0]  loops_q;
  logic [2:0]  cool_n_q;

  // cool-down length is n+1 units; long enough to need 20 bits
  function automatic logic [19:0] cool_len(input logic [2:0] n);
    cool_len = 20'(COOL_CYCLES * (int'(n) + 1)) - 20'h1;
  endfunction

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= panel_setup_pkg::ST_IDLE;
      timer_q  <= 20'h0;
      loops_q  <= 3'h0;
      cool_n_q <= 3'h0;
    end else if (ce) begin
      case (state_q)
        panel_setup_pkg::ST_IDLE: begin
          if (soft_reset_go) begin
            state_q <= panel_setup_pkg::ST_SRST;
            timer_q <= 20'(`SOFT_RESET_CYCLES);
          end else if (cmd_stb && byte_val == `CMD_INIT_CODE_PROGRAM && clock_stage_on) begin
            state_q <= panel_setup_pkg::ST_PROG;
          end else if (hv_go) begin
            cool_n_q <= byte_val[6:4];
            loops_q  <= byte_val[2:0];
            timer_q  <= cool_len(byte_val[6:4]);
            // zero loops means one check with no cool-down
            state_q  <= (byte_val[2:0] == 3'h0) ? panel_setup_pkg::ST_CHECK
                                                : panel_setup_pkg::ST_COOL;
          end else if (vci_go) begin
            state_q <= panel_setup_pkg::ST_VCI;
            timer_q <= 20'(`SUPPLY_CHECK_CYCLES);
          end
        end
        panel_setup_pkg::ST_SRST, panel_setup_pkg::ST_VCI: begin
          if (timer_q == 20'h0) state_q <= panel_setup_pkg::ST_IDLE;
          else timer_q <= timer_q - 20'h1;
        end
        panel_setup_pkg::ST_PROG: begin
          if (otp_done) state_q <= panel_setup_pkg::ST_IDLE;
        end
        panel_setup_pkg::ST_COOL: begin
          if (timer_q == 20'h0) state_q <= panel_setup_pkg::ST_CHECK;
          else timer_q <= timer_q - 20'h1;
        end
        panel_setup_pkg::ST_CHECK: begin
          // a ready level ends the loops early
          if (hv_ok_s || loops_q <= 3'h1) begin
            state_q <= panel_setup_pkg::ST_IDLE;
          end else begin
            loops_q <= loops_q - 3'h1;
            timer_q <= cool_len(cool_n_q);
            state_q <= panel_setup_pkg::ST_COOL;
          end
        end
        default: state_q <= panel_setup_pkg::ST_IDLE;
      endcase
    end
  end

  // straight from the state so no extra cycle; ce low holds it as it is
  assign busy = (state_q != panel_setup_pkg::ST_IDLE);

  // operation strobes and posted results
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      otp_program_start    <= 1'b0;
      init_code_load_start <= 1'b0;
    end else if (ce) begin
      otp_program_start    <= cmd_stb & (byte_val == `CMD_INIT_CODE_PROGRAM) & clock_stage_on;
      init_code_load_start <= cmd_stb & (byte_val == `CMD_INIT_CODE_LOAD);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hv_ready_result   <= 1'b0;
      supply_low_result <= 1'b0;
    end else if (ce) begin
      if (state_q == panel_setup_pkg::ST_CHECK) hv_ready_result <= hv_ok_s;
      if (state_q == panel_setup_pkg::ST_VCI && timer_q == 20'h0) supply_low_result <= vci_low_s;
    end
  end

endmodule
`default_nettype wire

// file: tb/panel_setup_sva.sv
// assertions on the ports of the setup command block
// assumes it is bound onto panel_driver_setup_commands, one clock domain
`timescale 1ns/1ps
`default_nettype none
module panel_setup_sva (
  // clock and reset
  input wire logic       mclk,
  input wire logic       resetn,
  // watched signals
  input wire logic       clock_stage_on,
  input wire logic       busy,
  input wire logic       otp_program_start,
  input wire logic       init_code_load_start,
  input wire logic       hv_ready_result,
  input wire logic [7:0] booster_phase1,
  input wire logic [7:0] booster_phase2,
  input wire logic [7:0] booster_phase3,
  input wire logic [7:0] booster_duration,
  input wire logic [1:0] sleep_mode,
  input wire logic [7:0] thermal_source
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  property p_prog_busy;
    otp_program_start |-> ##[0:2] busy;
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("busy missing after program start");
  property p_prog_pulse;
    otp_program_start |=> !otp_program_start;
  endproperty
  a_prog_pulse: assert property (p_prog_pulse) else $error("program start longer than one cycle");
  property p_load_pulse;
    init_code_load_start |=> !init_code_load_start;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load start longer than one cycle");
  // the stage enable may be sampled up to two edges before the strobe appears
  property p_prog_clk;
    otp_program_start |-> clock_stage_on || $past(clock_stage_on) || $past(clock_stage_on, 2);
  endproperty
  a_prog_clk: assert property (p_prog_clk) else $error("program started without clock stage");
  property p_phase_bit7;
    booster_phase1[7] && booster_phase2[7] && booster_phase3[7];
  endproperty
  a_phase_bit7: assert property (p_phase_bit7) else $error("phase byte bit 7 not one");
  property p_dur_top;
    booster_duration[7:6] == 2'h0;
  endproperty
  a_dur_top: assert property (p_dur_top) else $error("duration top bits not zero");
  property p_sleep_hold;
    (sleep_mode != 2'h0) [*2] |-> $stable(thermal_source);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("setting changed in deep sleep");
  property p_result_busy;
    $changed(hv_ready_result) |-> busy || $past(busy);
  endproperty
  a_result_busy: assert property (p_result_busy) else $error("ready result changed outside detection");

  c_prog: cover property (otp_program_start);
  c_load: cover property (init_code_load_start);
  c_sleep2: cover property (sleep_mode == 2'h3);
  c_ready: cover property (hv_ready_result);
endmodule

bind panel_driver_setup_commands panel_setup_sva panel_setup_sva_inst (
  .mclk(mclk), .resetn(resetn), .clock_stage_on(clock_stage_on), .busy(busy),
  .otp_program_start(otp_program_start), .init_code_load_start(init_code_load_start),
  .hv_ready_result(hv_ready_result), .booster_phase1(booster_phase1), .booster_phase2(booster_phase2),
  .booster_phase3(booster_phase3), .booster_duration(booster_duration), .sleep_mode(sleep_mode),
  .thermal_source(thermal_source));
`default_nettype wire

// file: tb/host_serial_model.sv
// host controller model writing bytes over the 4-wire serial port
// assumes a 100 ns mclk; serial clock of 800 ns made only inside frames
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  // reference clock
  input  wire logic mclk,
  // serial pins
  output var logic  csn,
  output var logic  scl,
  output var logic  sda,
  output var logic  dc_select
);
  initial begin
    csn = 1'b1;
    scl = 1'b0;
    sda = 1'b0;
    dc_select = 1'b0;
  end

  // one byte per frame; dc_select held over the whole byte
  task automatic send(input logic dc, input logic [7:0] b);
    int i;
    @(negedge mclk);
    csn = 1'b0;
    dc_select = dc;
    repeat (4) @(negedge mclk);
    for (i = 7; i >= 0; i--) begin
      sda = b[i];
      repeat (4) @(negedge mclk);
      scl = 1'b1;
      repeat (4) @(negedge mclk);
      scl = 1'b0;
    end
    repeat (4) @(negedge mclk);
    csn = 1'b1;
    // deselected data line must not keep a meaningful level
    sda = ~sda;
    repeat (4) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_panel_driver_setup_commands.sv
// self-checking bench for the setup command block
// assumes the block, the host model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_panel_driver_setup_commands;
  logic        mclk, resetn, clock_stage_on, analog_stage_on;
  logic        high_drive_voltage_ok, supply_input_level_low, otp_done, ce;
  wire logic   csn, scl, sda, dc_select;
  logic        busy, otp_program_start, init_code_load_start, hv_ready_result, supply_low_result;
  logic [8:0]  gate_line_count;
  logic        first_gate_select, interlace_scan_select, address_update_axis;
  logic [4:0]  gate_high_level;
  logic [7:0]  positive_source_level_a, positive_source_level_b, negative_source_level, thermal_source;
  logic [31:0] initial_code;
  logic [7:0]  booster_phase1, booster_phase2, booster_phase3, booster_duration;
  logic [1:0]  sleep_mode, address_step_direction;
  logic [6:0]  hv_check_setting;
  logic [2:0]  supply_level_code;
  int          err_count, comparisons, run, last_run, prog_pulses, load_pulses;

  panel_driver_setup_commands #(.COOL_CYCLES(10)) panel_driver_setup_commands_inst (
    .mclk(mclk), .resetn(resetn), .ce(ce), .csn(csn), .scl(scl), .sda(sda), .dc_select(dc_select),
    .busy(busy), .clock_stage_on(clock_stage_on), .analog_stage_on(analog_stage_on),
    .high_drive_voltage_ok(high_drive_voltage_ok), .supply_input_level_low(supply_input_level_low),
    .otp_done(otp_done), .otp_program_start(otp_program_start), .init_code_load_start(init_code_load_start),
    .hv_ready_result(hv_ready_result), .supply_low_result(supply_low_result), .gate_line_count(gate_line_count),
    .first_gate_select(first_gate_select), .interlace_scan_select(interlace_scan_select),
    .gate_high_level(gate_high_level), .positive_source_level_a(positive_source_level_a),
    .positive_source_level_b(positive_source_level_b), .negative_source_level(negative_source_level),
    .initial_code(initial_code), .booster_phase1(booster_phase1), .booster_phase2(booster_phase2),
    .booster_phase3(booster_phase3), .booster_duration(booster_duration), .sleep_mode(sleep_mode),
    .address_step_direction(address_step_direction), .address_update_axis(address_update_axis),
    .hv_check_setting(hv_check_setting), .supply_level_code(supply_level_code), .thermal_source(thermal_source));
  host_serial_model host_serial_model_inst (.mclk(mclk), .csn(csn), .scl(scl), .sda(sda), .dc_select(dc_select));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // busy run length and strobe counts, seen from outside
  always @(posedge mclk) begin
    if (busy === 1'b1) run <= run + 1;
    else begin
      if (run != 0) last_run <= run;
      run <= 0;
    end
    if (otp_program_start === 1'b1) prog_pulses <= prog_pulses + 1;
    if (init_code_load_start === 1'b1) load_pulses <= load_pulses + 1;
  end

  task report_and_stop;
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task cmd(input logic [7:0] c);
    host_serial_model_inst.send(1'b0, c);
  endtask
  task par(input logic [7:0] p);
    host_serial_model_inst.send(1'b1, p);
  endtask
  task wait_idle;
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 300) begin
      @(negedge mclk);
      i++;
    end
    if (i >= 300) begin
      err_count++;
      report_and_stop();
    end
    repeat (2) @(negedge mclk);
  endtask
  task hw_reset;
    @(negedge mclk);
    resetn = 1'b0;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
  endtask
  task check_defaults;
    chk("gate", {gate_line_count, first_gate_select, interlace_scan_select, gate_high_level}, {9'h127, 7'h00});
    chk("source", {positive_source_level_a, positive_source_level_b, negative_source_level}, 24'h41a832);
    chk("booster", {booster_phase1, booster_phase2, booster_phase3, booster_duration}, 32'h8b9c960f);
    chk("misc", {address_step_direction, address_update_axis, hv_check_setting, supply_level_code, thermal_source},
        {2'h3, 1'b0, 7'h00, 3'h4, 8'h48});
    chk("init", initial_code, 32'h0);
  endtask

  task t_gate;
    cmd(8'h01); par(8'hff); par(8'h01); par(8'h04);
    chk("gate_a", {gate_line_count, first_gate_select, interlace_scan_select}, {9'h1ff, 2'b10});
    cmd(8'h01); par(8'h2b); par(8'h00); par(8'h02);
    chk("gate_b", {gate_line_count, first_gate_select, interlace_scan_select}, {9'h02b, 2'b01});
  endtask
  task t_levels;
    cmd(8'h03); par(8'h17);
    chk("vgate", gate_high_level, 5'h17);
    cmd(8'h03); par(8'h1f);
    chk("vgate_undef", gate_high_level, 5'h1f);
    cmd(8'h04); par(8'h23); par(8'h8e); par(8'h0a);
    chk("source", {positive_source_level_a, positive_source_level_b, negative_source_level}, 24'h238e0a);
    cmd(8'h0c); par(8'h15); par(8'h80); par(8'hff); par(8'hff);
    chk("booster", {booster_phase1, booster_phase2, booster_phase3, booster_duration}, 32'h9580ff3f);
  endtask
  task t_entry;
    int i;
    for (i = 0; i < 4; i++) begin
      cmd(8'h11); par({5'h00, i[0], i[1:0]});
      chk("entry", {address_update_axis, address_step_direction}, {i[0], i[1:0]});
    end
  endtask
  task t_init;
    cmd(8'h09); par(8'hde); par(8'had); par(8'hbe); par(8'hef);
    chk("init", initial_code, 32'hdeadbeef);
    cmd(8'h0a);
    chk("load", load_pulses, 1);
    cmd(8'h7f); par(8'h00);
    chk("unknown", {thermal_source, gate_high_level}, {8'h48, 5'h1f});
  endtask
  task t_program;
    cmd(8'h08);
    chk("prog_off", {prog_pulses[0], busy}, 2'b00);
    clock_stage_on = 1'b1;
    cmd(8'h08);
    chk("prog_on", {prog_pulses[0], busy}, 2'b11);
    // host ignores busy here on purpose: the byte pair must be dropped
    cmd(8'h18); par(8'h80);
    otp_done = 1'b1;
    @(negedge mclk);
    otp_done = 1'b0;
    wait_idle();
    chk("busy_drop", thermal_source, 8'h48);
  endtask
  task t_detect;
    analog_stage_on = 1'b1;
    supply_input_level_low = 1'b1;
    last_run = 0;
    cmd(8'h15); par(8'h03); wait_idle();
    chk("vci", {last_run[7:0], supply_low_result, supply_level_code}, {8'd33, 1'b1, 3'h3});
    last_run = 0;
    cmd(8'h14); par(8'h12); wait_idle();
    chk("hv_loops", {last_run[7:0], hv_ready_result}, {8'd42, 1'b0});
    chk("hv_set", hv_check_setting, 7'h12);
    high_drive_voltage_ok = 1'b1;
    last_run = 0;
    cmd(8'h14); par(8'h00); wait_idle();
    chk("hv_once", {last_run[7:0], hv_ready_result}, {8'd1, 1'b1});
    analog_stage_on = 1'b0;
    last_run = 0;
    cmd(8'h15); par(8'h07); wait_idle();
    chk("vci_off", {last_run[7:0], supply_level_code}, {8'd0, 3'h7});
  endtask
  task t_softreset;
    last_run = 0;
    cmd(8'h12); wait_idle();
    chk("srst_len", last_run, 17);
    check_defaults();
    // ce low for five edges mid-run must stretch busy by five cycles
    last_run = 0;
    cmd(8'h12);
    ce = 1'b0;
    repeat (5) @(negedge mclk);
    ce = 1'b1;
    wait_idle();
    chk("srst_ce", last_run, 22);
  endtask
  task t_sleep;
    logic [1:0] codes [3];
    int k;
    codes = '{2'h0, 2'h1, 2'h3};
    for (k = 0; k < 3; k++) begin
      cmd(8'h18); par(8'h11);
      cmd(8'h10); par({6'h00, codes[k]});
      chk("sleep", sleep_mode, codes[k]);
      cmd(8'h18); par(8'h22);
      chk("sleep_drop", thermal_source, (codes[k] == 2'h0) ? 8'h22 : 8'h11);
      hw_reset();
      chk("wake", sleep_mode, 2'h0);
    end
  endtask

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    clock_stage_on = 1'b0;
    analog_stage_on = 1'b0;
    high_drive_voltage_ok = 1'b0;
    supply_input_level_low = 1'b0;
    otp_done = 1'b0;
    {err_count, comparisons, run, last_run, prog_pulses, load_pulses} = '0;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    chk("sleep_rst", sleep_mode, 2'h0);
    check_defaults();
    t_gate();
    t_levels();
    t_entry();
    t_init();
    t_program();
    t_detect();
    t_softreset();
    t_sleep();
    report_and_stop();
  end
endmodule
`default_nettype wire
